// ---- pkg/sacs_consts.svh ----
`ifndef SACS_CONSTS_SVH
`define SACS_CONSTS_SVH
// Functional notes
// - Run link hardware check at power-on and after reset command; flag link fault.
// - On link hardware fault, never establish communication; stop link initialization.
// - On link hardware fault, link state stays in or returns to initial.
// - Link hardware fault ignores alarm clear; only power cycle removes it.
// - Current detector malfunction raises the hardware self-diagnostic fault code.
// - Control circuit malfunction or failed self-diagnosis raises the other-fault code.
// - Dynamic brake releases about 2 ms after an accepted clear.
// - Servo-on status output turns on about 25 ms after the clear; the code waits 25 ms after brake release, 27 ms in all.
// - Motor energization begins about 60 ms after the clear; the code waits 60 ms after servo-on status, 87 ms in all.
// - Brake release output turns on about 4 ms after energization.
// - Servo-on status shows only servo-on received, not command acceptance.
// - Torque overload persisting beyond the allowed time trips protection and stops.
`define SACS_CLK_MHZ 125
`define SACS_T_CLEAR_MS 16
`define SACS_T_DB_MS 2
`define SACS_T_SON_MS 25
`define SACS_T_ENERG_MS 60
`define SACS_T_BRK_MS 4
`define SACS_MS_CYC (`SACS_CLK_MHZ * 1000)
`define SACS_CODE_NONE 8'h00
`define SACS_CODE_LINK 8'h01
`define SACS_CODE_SELFDIAG 8'h02
`define SACS_CODE_OTHER 8'h03
`define SACS_CODE_OVERLOAD 8'h04
`endif

// ---- pkg/sacs_pkg.sv ----
package sacs_pkg;
  typedef enum logic [5:0] {
    SQ_FAULT = 6'h01,
    SQ_WAIT_DB = 6'h02,
    SQ_WAIT_SON = 6'h04,
    SQ_WAIT_EN = 6'h08,
    SQ_WAIT_BRK = 6'h10,
    SQ_READY = 6'h20
  } sacs_seq_t;
  typedef enum logic [2:0] {
    LK_INITIAL = 3'h1,
    LK_CHECK = 3'h2,
    LK_OPER = 3'h4
  } sacs_link_t;
endpackage

// ---- rtl/sacs_top.sv ----
`timescale 1ns/1ps
`include "sacs_consts.svh"
module sacs_top #(
  parameter int unsigned CLEAR_CYC = `SACS_T_CLEAR_MS * `SACS_MS_CYC,
  parameter int unsigned DB_CYC = `SACS_T_DB_MS * `SACS_MS_CYC,
  parameter int unsigned SON_CYC = `SACS_T_SON_MS * `SACS_MS_CYC,
  parameter int unsigned ENERG_CYC = `SACS_T_ENERG_MS * `SACS_MS_CYC,
  parameter int unsigned BRK_CYC = `SACS_T_BRK_MS * `SACS_MS_CYC
) (
  // Clock, reset, enable.
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Host and fault sources.
  input wire logic reset_cmd,
  input wire logic link_hw_ok,
  input wire logic link_check_done,
  input wire logic cur_det_fault,
  input wire logic ctrl_fault,
  input wire logic overload_trip,
  input wire logic servo_on_cmd,
  input wire logic alarm_clear_cmd,
  input wire logic motion_cmd_valid,
  // Status outputs.
  output logic fault_alarm_output,
  output logic [7:0] fault_code,
  output logic comm_fault_lamp,
  output logic link_established,
  output logic dyn_brake_on,
  output logic servo_on_status,
  output logic motor_energized,
  output logic brake_release_output,
  output logic servo_ready,
  output logic motion_cmd_accept
);
  sacs_pkg::sacs_seq_t seq_q, seq_d;
  sacs_pkg::sacs_link_t link_q, link_d;
  logic link_fault_q;
  logic [31:0] clr_cnt_q, seq_cnt_q;
  logic clr_ok_q;
  logic [7:0] code_q;

  // Only a power cycle (resetn) clears the link fault; a reset command reruns the check only while no link fault is latched.
  wire start_check = reset_cmd & ~link_fault_q;
  wire link_fail = (link_q == sacs_pkg::LK_CHECK) & link_check_done & ~link_hw_ok;
  wire soft_fault = cur_det_fault | ctrl_fault | overload_trip;
  wire any_fault = link_fault_q | link_fail | soft_fault;
  wire clear_accept = clr_ok_q & ~alarm_clear_cmd & servo_on_cmd & ~link_fault_q & ~soft_fault;
  wire [7:0] new_code = link_fail ? `SACS_CODE_LINK :
                        cur_det_fault ? `SACS_CODE_SELFDIAG :
                        ctrl_fault ? `SACS_CODE_OTHER :
                        overload_trip ? `SACS_CODE_OVERLOAD : code_q;
  wire seq_tick_db = seq_cnt_q == DB_CYC - 1;
  wire seq_tick_son = seq_cnt_q == SON_CYC - 1;
  wire seq_tick_en = seq_cnt_q == ENERG_CYC - 1;
  wire seq_tick_brk = seq_cnt_q == BRK_CYC - 1;

  always_comb begin
    link_d = link_q;
    unique case (link_q)
      sacs_pkg::LK_INITIAL: if (!link_fault_q) link_d = sacs_pkg::LK_CHECK;
      sacs_pkg::LK_CHECK: begin
        if (link_fail) link_d = sacs_pkg::LK_INITIAL;
        else if (link_check_done) link_d = sacs_pkg::LK_OPER;
      end
      sacs_pkg::LK_OPER: if (start_check) link_d = sacs_pkg::LK_CHECK;
      default: link_d = sacs_pkg::LK_INITIAL;
    endcase
    if (link_fault_q) link_d = sacs_pkg::LK_INITIAL;
  end

  // Timed steps, each counted from the previous one: 2 ms, 25 ms, 60 ms, then 4 ms after energization.
  always_comb begin
    seq_d = seq_q;
    unique case (seq_q)
      sacs_pkg::SQ_FAULT: if (clear_accept) seq_d = sacs_pkg::SQ_WAIT_DB;
      sacs_pkg::SQ_WAIT_DB: if (seq_tick_db) seq_d = sacs_pkg::SQ_WAIT_SON;
      sacs_pkg::SQ_WAIT_SON: if (seq_tick_son) seq_d = sacs_pkg::SQ_WAIT_EN;
      sacs_pkg::SQ_WAIT_EN: if (seq_tick_en) seq_d = sacs_pkg::SQ_WAIT_BRK;
      sacs_pkg::SQ_WAIT_BRK: if (seq_tick_brk) seq_d = sacs_pkg::SQ_READY;
      sacs_pkg::SQ_READY: ;
      default: seq_d = sacs_pkg::SQ_FAULT;
    endcase
    if (any_fault || (seq_q != sacs_pkg::SQ_FAULT && !servo_on_cmd)) seq_d = sacs_pkg::SQ_FAULT;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      seq_q <= sacs_pkg::SQ_FAULT;
      link_q <= sacs_pkg::LK_INITIAL;
      link_fault_q <= 1'b0;
      clr_cnt_q <= 32'h0000_0000;
      clr_ok_q <= 1'b0;
      seq_cnt_q <= 32'h0000_0000;
      code_q <= `SACS_CODE_NONE;
    end else if (clk_en) begin
      seq_q <= seq_d;
      link_q <= link_d;
      if (link_fail) link_fault_q <= 1'b1;
      if (alarm_clear_cmd) begin
        if (clr_cnt_q != CLEAR_CYC) clr_cnt_q <= clr_cnt_q + 32'h0000_0001;
      end else clr_cnt_q <= 32'h0000_0000;
      clr_ok_q <= alarm_clear_cmd & (clr_cnt_q >= CLEAR_CYC - 1);
      // Step timing restarts in each state; the brake delay counts from energization.
      if (seq_d != seq_q) seq_cnt_q <= 32'h0000_0000;
      else seq_cnt_q <= seq_cnt_q + 32'h0000_0001;
      // The code, and with it the alarm, stands until the whole clear sequence has finished.
      if (any_fault) code_q <= new_code;
      else if (seq_d == sacs_pkg::SQ_READY && seq_q != sacs_pkg::SQ_READY) code_q <= `SACS_CODE_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      fault_alarm_output <= 1'b0;
      fault_code <= 8'h00;
      comm_fault_lamp <= 1'b0;
      link_established <= 1'b0;
      dyn_brake_on <= 1'b1;
      servo_on_status <= 1'b0;
      motor_energized <= 1'b0;
      brake_release_output <= 1'b0;
      servo_ready <= 1'b0;
      motion_cmd_accept <= 1'b0;
    end else if (clk_en) begin
      fault_alarm_output <= (code_q != `SACS_CODE_NONE) & (seq_q != sacs_pkg::SQ_READY);
      fault_code <= code_q;
      comm_fault_lamp <= link_fault_q;
      link_established <= (link_q == sacs_pkg::LK_OPER) & ~link_fault_q;
      dyn_brake_on <= (seq_q == sacs_pkg::SQ_FAULT) | (seq_q == sacs_pkg::SQ_WAIT_DB);
      // Servo-on status reports the command once the servo-on wait has passed, never readiness for motion.
      servo_on_status <= servo_on_cmd & (seq_q != sacs_pkg::SQ_FAULT) & (seq_q != sacs_pkg::SQ_WAIT_DB) &
                         (seq_q != sacs_pkg::SQ_WAIT_SON);
      motor_energized <= (seq_q == sacs_pkg::SQ_WAIT_BRK) | (seq_q == sacs_pkg::SQ_READY);
      brake_release_output <= seq_q == sacs_pkg::SQ_READY;
      servo_ready <= seq_q == sacs_pkg::SQ_READY;
      motion_cmd_accept <= motion_cmd_valid & (seq_q == sacs_pkg::SQ_READY);
    end
  end

  // Link fault handling.
  chk_link_fault_sticky: assert property (@(posedge clock) disable iff (!resetn)
    link_fault_q |=> link_fault_q)
    else $error("link fault cleared without power cycle");
  chk_link_no_oper: assert property (@(posedge clock) disable iff (!resetn)
    link_fault_q |-> link_q != sacs_pkg::LK_OPER)
    else $error("link operational during fault");
  chk_link_no_estab: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && link_fault_q |=> !link_established)
    else $error("link established during fault");
  chk_link_fail_code: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && link_fail |=> link_fault_q && code_q == `SACS_CODE_LINK)
    else $error("link fault not flagged");
  chk_link_fail_init: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && link_fail |=> link_q == sacs_pkg::LK_INITIAL)
    else $error("link state not initial after fault");
  chk_link_lamp_on: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && link_fault_q |=> comm_fault_lamp)
    else $error("link fault lamp off");
  chk_link_hold_fault: assert property (@(posedge clock) disable iff (!resetn)
    link_fault_q |-> seq_q == sacs_pkg::SQ_FAULT)
    else $error("sequence left fault state during link fault");

  // Clear sequence order and step lengths.
  chk_short_clear: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && seq_q == sacs_pkg::SQ_FAULT && !clr_ok_q |=> seq_q == sacs_pkg::SQ_FAULT)
    else $error("clear accepted without full hold");
  chk_db_release: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && seq_q == sacs_pkg::SQ_WAIT_SON |=> !dyn_brake_on)
    else $error("brake not released");
  chk_db_count: assert property (@(posedge clock) disable iff (!resetn)
    seq_q == sacs_pkg::SQ_WAIT_DB |-> seq_cnt_q < DB_CYC)
    else $error("brake release step too long");
  chk_son_order: assert property (@(posedge clock) disable iff (!resetn)
    servo_on_status |-> !dyn_brake_on)
    else $error("status on before brake release");
  chk_son_count: assert property (@(posedge clock) disable iff (!resetn)
    seq_q == sacs_pkg::SQ_WAIT_SON |-> seq_cnt_q < SON_CYC)
    else $error("servo-on step too long");
  chk_energ_order: assert property (@(posedge clock) disable iff (!resetn)
    motor_energized |-> !dyn_brake_on)
    else $error("energized with brake on");
  chk_energ_count: assert property (@(posedge clock) disable iff (!resetn)
    seq_q == sacs_pkg::SQ_WAIT_EN |-> seq_cnt_q < ENERG_CYC)
    else $error("energization step too long");
  chk_brake_order: assert property (@(posedge clock) disable iff (!resetn)
    brake_release_output |-> motor_energized)
    else $error("brake released unpowered");
  chk_brk_count: assert property (@(posedge clock) disable iff (!resetn)
    seq_q == sacs_pkg::SQ_WAIT_BRK |-> seq_cnt_q < BRK_CYC)
    else $error("brake release output step too long");
  chk_ready_brake: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && seq_q == sacs_pkg::SQ_READY |=> brake_release_output && servo_ready)
    else $error("ready state outputs missing");
  chk_son_cmd_only: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && !servo_on_cmd |=> !servo_on_status)
    else $error("servo-on status without command");

  // Alarm, ready and command gating.
  chk_ready_alarm: assert property (@(posedge clock) disable iff (!resetn)
    servo_ready |-> !fault_alarm_output)
    else $error("ready while alarm");
  chk_alarm_hold: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && code_q != `SACS_CODE_NONE && seq_q != sacs_pkg::SQ_READY |=> fault_alarm_output)
    else $error("alarm dropped before sequence end");
  chk_cmd_gate: assert property (@(posedge clock) disable iff (!resetn)
    motion_cmd_accept |-> $past(seq_q) == sacs_pkg::SQ_READY)
    else $error("command before ready");
  chk_no_early_cmd: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && seq_q != sacs_pkg::SQ_READY |=> !motion_cmd_accept)
    else $error("command accepted before ready");

  // Fault codes and stop on fault.
  chk_selfdiag_code: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && cur_det_fault && !link_fail |=> code_q == `SACS_CODE_SELFDIAG)
    else $error("bad code");
  chk_other_code: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && ctrl_fault && !link_fail && !cur_det_fault |=> code_q == `SACS_CODE_OTHER)
    else $error("bad other code");
  chk_alarm_has_code: assert property (@(posedge clock) disable iff (!resetn)
    fault_alarm_output |-> fault_code != `SACS_CODE_NONE)
    else $error("alarm without fault code");
  chk_overload_code: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && overload_trip && !link_fail && !cur_det_fault && !ctrl_fault |=> code_q == `SACS_CODE_OVERLOAD)
    else $error("bad overload code");
  chk_fault_stop: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && any_fault |=> seq_q == sacs_pkg::SQ_FAULT)
    else $error("fault did not stop operation");
endmodule // sacs_top

// ---- test/sacs_host_model.sv ----
`timescale 1ns/1ps
module sacs_host_model (
  // Clock.
  input wire logic clock,
  // Commands to the drive.
  output logic servo_on_cmd,
  output logic alarm_clear_cmd
);
  initial begin
    servo_on_cmd = 1'b0;
    alarm_clear_cmd = 1'b0;
  end
  // The host raises servo-on with each clear and can drop it; a hold below the minimum is only sent to prove it is refused.
  task automatic send_clear(input int hold);
    servo_on_cmd = 1'b1;
    alarm_clear_cmd = 1'b1;
    repeat (hold) @(posedge clock);
    #1 alarm_clear_cmd = 1'b0;
  endtask
  task automatic set_servo_on(input logic on);
    servo_on_cmd = on;
  endtask
endmodule // sacs_host_model

// ---- test/servo_alarm_clear_sequencer_tb.sv ----
`timescale 1ns/1ps
module servo_alarm_clear_sequencer_tb;
  localparam int CLR = 20, DB = 4, SON = 6, EN = 8, BRK = 5;
  logic clock, resetn, clk_en, reset_cmd, link_hw_ok, link_check_done, cur_det_fault, ctrl_fault, overload_trip;
  logic servo_on_cmd, alarm_clear_cmd, motion_cmd_valid, fault_alarm_output, comm_fault_lamp, link_established;
  logic dyn_brake_on, servo_on_status, motor_energized, brake_release_output, servo_ready, motion_cmd_accept;
  logic [7:0] fault_code;
  logic [31:0] seed = 32'h0000_5038;
  int bad_count = 0, checks = 0;
  sacs_top #(.CLEAR_CYC(CLR), .DB_CYC(DB), .SON_CYC(SON), .ENERG_CYC(EN), .BRK_CYC(BRK)) u_sacs_top (
    .clock, .resetn, .clk_en, .reset_cmd, .link_hw_ok, .link_check_done, .cur_det_fault, .ctrl_fault,
    .overload_trip, .servo_on_cmd, .alarm_clear_cmd, .motion_cmd_valid, .fault_alarm_output, .fault_code,
    .comm_fault_lamp, .link_established, .dyn_brake_on, .servo_on_status, .motor_energized,
    .brake_release_output, .servo_ready, .motion_cmd_accept);
  sacs_host_model u_sacs_host_model (.clock, .servo_on_cmd, .alarm_clear_cmd);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Counts cycles until the level shows; a missing edge ends the run instead of hanging.
  task automatic wait_lvl(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 200) begin
      step(1);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic clear_and_check(input int hold);
    int n;
    u_sacs_host_model.send_clear(hold);
    chk(8'(servo_ready | motion_cmd_accept), 8'h00);
    wait_lvl(dyn_brake_on, 1'b0, n);
    chk(8'(n), 8'(DB + 2));
    wait_lvl(servo_on_status, 1'b1, n);
    chk(8'(n), 8'(SON));
    chk(8'(motion_cmd_accept | servo_ready), 8'h00);
    wait_lvl(motor_energized, 1'b1, n);
    chk(8'(n), 8'(EN));
    wait_lvl(brake_release_output, 1'b1, n);
    chk(8'(n), 8'(BRK));
    step(2);
    chk({5'h00, servo_ready, fault_alarm_output, motion_cmd_accept}, 8'h05);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
  initial begin
    {resetn, reset_cmd, link_hw_ok, link_check_done, cur_det_fault, ctrl_fault, overload_trip} = 7'h00;
    motion_cmd_valid = 1'b1;
    clk_en = 1'b1;
    step(8);
    resetn = 1'b1;
    chk({6'h00, dyn_brake_on, servo_ready}, 8'h02);
    step(1);
    {link_hw_ok, link_check_done} = 2'h3;
    step(1);
    link_check_done = 1'b0;
    step(2);
    chk(8'(link_established), 8'h01);
    seed = xs(seed);
    u_sacs_host_model.send_clear(CLR - 1 - int'(seed[1:0]));
    step(DB + SON + 4);
    chk(8'(dyn_brake_on), 8'h01);
    clear_and_check(CLR);
    for (int k = 0; k < 3; k++) begin
      {overload_trip, ctrl_fault, cur_det_fault} = 3'h1 << k;
      step(3);
      chk(fault_code, 8'h02 + 8'(k));
      chk({5'h00, fault_alarm_output, dyn_brake_on, servo_ready}, 8'h06);
      {overload_trip, ctrl_fault, cur_det_fault} = 3'h0;
      seed = xs(seed);
      step(1);
      clear_and_check(CLR + int'(seed[2:0]));
    end
    u_sacs_host_model.set_servo_on(1'b0);
    step(2);
    chk({5'h00, servo_ready, dyn_brake_on, servo_on_status}, 8'h02);
    clear_and_check(CLR);
    clk_en = 1'b0;
    cur_det_fault = 1'b1;
    step(3);
    chk({fault_code[6:0], servo_ready}, 8'h01);
    cur_det_fault = 1'b0;
    clk_en = 1'b1;
    step(2);
    chk({fault_code[6:0], servo_ready}, 8'h01);
    reset_cmd = 1'b1;
    step(1);
    {reset_cmd, link_hw_ok, link_check_done} = 3'h1;
    step(1);
    link_check_done = 1'b0;
    step(3);
    chk(fault_code, 8'h01);
    chk({6'h00, comm_fault_lamp, link_established}, 8'h02);
    u_sacs_host_model.send_clear(CLR + 2);
    step(DB + SON + EN + BRK + 4);
    chk({fault_code[3:0], 3'h0, servo_ready}, 8'h10);
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    step(1);
    chk({fault_code[6:0], comm_fault_lamp}, 8'h00);
    print_verdict();
  end
endmodule // servo_alarm_clear_sequencer_tb
